// [pxsc_regs.svh]
/*
  Register constants for the secondary-status capability block: offsets,
  field positions, fixed values and reset values.
  Assumes it is included by bare name from the package and the modules.
*/
`ifndef PXSC_REGS_SVH
`define PXSC_REGS_SVH

// Byte offsets on the register port
`define PXSC_CAP_OFS 8'h80
`define PXSC_MASK_OFS 8'hF0

// Fixed capability header values
`define PXSC_CAP_ID 8'h07
`define PXSC_NEXT_PTR 8'h90

// Field positions in the capability dword
`define PXSC_ID_LSB 0
`define PXSC_NEXT_LSB 8
`define PXSC_W64_BIT 16
`define PXSC_FAST_BIT 17
`define PXSC_FLG_LSB 18
`define PXSC_FLG_W 4
`define PXSC_FREQ_LSB 22
`define PXSC_RSVD_LSB 25

// Flag indices inside the four-bit flag field
`define PXSC_FLG_DISC 0
`define PXSC_FLG_UNEXP 1
`define PXSC_FLG_OVR 2
`define PXSC_FLG_DLY 3

// Secondary clock frequency codes
`define PXSC_FREQ_CONV 3'h0
`define PXSC_FREQ_66 3'h1
`define PXSC_FREQ_133 3'h2

// Reset values
`define PXSC_FREQ_RST 3'h0
`define PXSC_FLG_RST 4'h0
`define PXSC_MASK_RST 4'h0
`define PXSC_RDATA_RST 32'h0000_0000

`endif

// [pxsc_pkg.sv]
/*
  Types for the secondary-status capability block.
  Assumes pxsc_regs.svh is on the include path.
*/
`default_nettype none

`include "pxsc_regs.svh"

package pxsc_pkg;

  // Strap capture phase after reset release
  typedef enum logic [1:0] {
    PXSC_WAIT1 = 2'b00,
    PXSC_WAIT2 = 2'b01,
    PXSC_SETTLE = 2'b10,
    PXSC_RUN = 2'b11
  } pxsc_phase_t;

  // Encoded secondary clock frequency
  typedef logic [2:0] pxsc_freq_t;

  // Sticky event flags, also the interrupt layout
  typedef logic [`PXSC_FLG_W-1:0] pxsc_flags_t;

  // Whole state of the block
  typedef struct packed {
    pxsc_phase_t phase;
    logic fwd;
    logic wide;
    pxsc_flags_t flags;
    pxsc_freq_t freq;
    pxsc_flags_t mask;
    logic [31:0] rdata;
    logic irq;
  } pxsc_state_t;

endpackage : pxsc_pkg

`default_nettype wire

// [pxsc_sync.sv]
/*
  Two-flop synchroniser for a bundle of slow pin levels.
  Assumes every bit is a quasi-static level; no coherency across bits.
*/
`timescale 1ns/1ps
`default_nettype none

module pxsc_sync #(
  parameter int WIDTH = 5
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  // First stage, read only by the second stage
  logic [WIDTH-1:0] meta_r;

  // Both stages clear to a constant under reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      dout <= '0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end

endmodule : pxsc_sync

`default_nettype wire

// [pxsc_caps.sv]
/*
  Secondary-status capability dword with interrupt mask and strap capture.
  Assumes a single-cycle register port, event pulses from logic on clk,
  and mode, wide-bus and frequency inputs coming straight from pins.
*/
// The strobed register port was left to the implementer.
// Summary of operation
// - Bit16 reads forward mode and wide strap
// - Bit17 reads one only in forward mode
// - Bit18 sticky in forward, zero in reverse
// - Discarded split completion sets bit18
// - Bit19 sticky in reverse, zero in forward
// - Unexpected own split completion sets bit19
// - Buffer-full completion cut sets bit20
// - Split request over commitment sets bit21
// - Bits24:22 hold secondary clock code
// - Frequency field zero in reverse mode
// - Low byte reads fixed identifier 07h
// - Bits15:8 read next pointer 90h
`timescale 1ns/1ps
`default_nettype none

`include "pxsc_regs.svh"

module pxsc_caps (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic fwd_mode_pin,
  input wire logic wide_bus_strap,
  input wire pxsc_pkg::pxsc_freq_t sec_freq_pin,
  input wire logic split_cpl_discard,
  input wire logic unexp_split_cpl,
  input wire logic split_cpl_overrun,
  input wire logic split_req_delayed,
  output logic irq
);
  import pxsc_pkg::*;

  // Registered state and its next value
  pxsc_state_t st_r;
  pxsc_state_t st_nxt;

  // Synchronised pin levels
  logic [4:0] pins_sync;
  logic sync_fwd;
  logic sync_wide;
  pxsc_freq_t sync_freq;

  // Assembled read value of the capability dword
  logic [31:0] cap_word;
  logic [31:0] mask_word;

  // Pins are asynchronous to clk, so they pass two flops first
  pxsc_sync #(
    .WIDTH(5)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .din({fwd_mode_pin, wide_bus_strap, sec_freq_pin}),
    .dout(pins_sync)
  );

  assign sync_fwd = pins_sync[4];
  assign sync_wide = pins_sync[3];
  assign sync_freq = pins_sync[2:0];

  // Capability dword as software sees it
  assign cap_word[`PXSC_ID_LSB +: 8] = `PXSC_CAP_ID;
  assign cap_word[`PXSC_NEXT_LSB +: 8] = `PXSC_NEXT_PTR;
  assign cap_word[`PXSC_W64_BIT] = st_r.fwd & st_r.wide;
  assign cap_word[`PXSC_FAST_BIT] = st_r.fwd;
  assign cap_word[`PXSC_FLG_LSB +: `PXSC_FLG_W] = st_r.flags;
  assign cap_word[`PXSC_FREQ_LSB +: 3] = st_r.freq;
  assign cap_word[31:`PXSC_RSVD_LSB] = 7'h00;

  // Mask word uses the same layout as the flags
  assign mask_word = {10'h000, st_r.mask, 18'h0_0000};

  // Next-state logic for the whole block
  always_comb begin
    pxsc_flags_t set_v;
    pxsc_flags_t clr_v;
    pxsc_flags_t legal_v;
    set_v = '0;
    clr_v = '0;
    legal_v = '0;
    st_nxt = st_r;
    st_nxt.rdata = `PXSC_RDATA_RST;

    // Straps are latched once the synchroniser has filled
    // Taking them once keeps the mode from flipping under live traffic
    case (st_r.phase)
      PXSC_WAIT1: begin
        st_nxt.phase = PXSC_WAIT2;
      end
      PXSC_WAIT2: begin
        st_nxt.phase = PXSC_SETTLE;
      end
      PXSC_SETTLE: begin
        st_nxt.phase = PXSC_RUN;
        st_nxt.fwd = sync_fwd;
        st_nxt.wide = sync_wide;
      end
      PXSC_RUN: begin
        st_nxt.phase = PXSC_RUN;
      end
      default: begin
        st_nxt.phase = PXSC_WAIT1;
      end
    endcase

    // Frequency code tracks the pin only in forward mode
    if (st_r.phase == PXSC_RUN && st_r.fwd) begin
      st_nxt.freq = sync_freq;
    end else begin
      st_nxt.freq = `PXSC_FREQ_RST;
    end

    // Events count only once the mode is known
    // A pulse during strap capture is dropped rather than filed in the wrong mode
    if (st_r.phase == PXSC_RUN) begin
      set_v[`PXSC_FLG_DISC] = split_cpl_discard & st_r.fwd;
      set_v[`PXSC_FLG_UNEXP] = unexp_split_cpl & ~st_r.fwd;
      set_v[`PXSC_FLG_OVR] = split_cpl_overrun;
      set_v[`PXSC_FLG_DLY] = split_req_delayed;
    end

    // Write-one-to-clear on the capability dword; other bits ignore writes
    if (reg_wr && reg_addr == `PXSC_CAP_OFS) begin
      clr_v = reg_wdata[`PXSC_FLG_LSB +: `PXSC_FLG_W];
    end

    // Mask register is plain read-write
    if (reg_wr && reg_addr == `PXSC_MASK_OFS) begin
      st_nxt.mask = reg_wdata[`PXSC_FLG_LSB +: `PXSC_FLG_W];
    end

    // Mode-dependent flags are forced to zero in the other mode
    legal_v[`PXSC_FLG_DISC] = st_r.fwd;
    legal_v[`PXSC_FLG_UNEXP] = ~st_r.fwd;
    legal_v[`PXSC_FLG_OVR] = 1'b1;
    legal_v[`PXSC_FLG_DLY] = 1'b1;

    // A set in the same cycle as a clear wins
    st_nxt.flags = ((st_r.flags & ~clr_v) | set_v) & legal_v;

    // Read data stand only in the cycle after the strobe
    // Idle and unmapped cycles return zero, so stale data never leak
    if (reg_rd) begin
      case (reg_addr)
        `PXSC_CAP_OFS: begin
          st_nxt.rdata = cap_word;
        end
        `PXSC_MASK_OFS: begin
          st_nxt.rdata = mask_word;
        end
        default: begin
          st_nxt.rdata = `PXSC_RDATA_RST;
        end
      endcase
    end

    // Level interrupt from unmasked flags, one cycle behind the flags
    // Registering costs a cycle of lag but keeps the pin free of glitches
    st_nxt.irq = |(st_r.flags & st_r.mask);
  end

  // The single state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r.phase <= PXSC_WAIT1;
      st_r.fwd <= 1'b0;
      st_r.wide <= 1'b0;
      st_r.flags <= `PXSC_FLG_RST;
      st_r.freq <= `PXSC_FREQ_RST;
      st_r.mask <= `PXSC_MASK_RST;
      st_r.rdata <= `PXSC_RDATA_RST;
      st_r.irq <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state flops
  assign reg_rdata = st_r.rdata;
  assign irq = st_r.irq;

  // Checks on the block's own outputs and state
  // All of them rest while reset is low; strap phases guard the rest
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // Helper: capability read in a settled phase
  logic cap_rd;
  assign cap_rd = reg_rd && reg_addr == `PXSC_CAP_OFS && st_r.phase == PXSC_RUN;

  a_wide_report: assert property (cap_rd |=> reg_rdata[16] == ($past(st_r.fwd) & $past(st_r.wide)))
    else $error("64-bit bit does not match mode and strap");

  a_fast_report: assert property (cap_rd |=> reg_rdata[17] == $past(st_r.fwd))
    else $error("133MHz bit does not match mode");

  a_disc_reverse: assert property (!st_r.fwd |=> !st_r.flags[`PXSC_FLG_DISC] || st_r.fwd)
    else $error("discard flag set in reverse mode");

  a_disc_set: assert property (st_r.phase == PXSC_RUN && st_r.fwd && split_cpl_discard
    |=> st_r.flags[`PXSC_FLG_DISC])
    else $error("discard event did not set flag");

  a_unexp_fwd: assert property (st_r.phase == PXSC_RUN && st_r.fwd |-> !st_r.flags[`PXSC_FLG_UNEXP])
    else $error("unexpected-completion flag set in forward mode");

  a_unexp_set: assert property (st_r.phase == PXSC_RUN && !st_r.fwd && unexp_split_cpl
    |=> st_r.flags[`PXSC_FLG_UNEXP])
    else $error("unexpected completion did not set flag");

  a_ovr_set: assert property (st_r.phase == PXSC_RUN && split_cpl_overrun
    |=> st_r.flags[`PXSC_FLG_OVR])
    else $error("overrun event did not set flag");

  a_dly_set: assert property (st_r.phase == PXSC_RUN && split_req_delayed
    |=> st_r.flags[`PXSC_FLG_DLY] [*1] ##1 st_r.flags[`PXSC_FLG_DLY] || $past(reg_wr))
    else $error("delayed request did not set flag");

  a_freq_track: assert property (st_r.phase == PXSC_RUN && st_r.fwd |=> st_r.freq == $past(sync_freq))
    else $error("frequency field does not follow pin");

  a_freq_reverse: assert property (!st_r.fwd |-> st_r.freq == `PXSC_FREQ_CONV)
    else $error("frequency field nonzero in reverse mode");

  a_hdr_fixed: assert property (cap_rd |=> reg_rdata[15:0] == {`PXSC_NEXT_PTR, `PXSC_CAP_ID})
    else $error("capability header reads wrong");

  a_flag_clear: assert property (reg_wr && reg_addr == `PXSC_CAP_OFS
    && reg_wdata[`PXSC_FLG_LSB + `PXSC_FLG_OVR] && !split_cpl_overrun |=> !st_r.flags[`PXSC_FLG_OVR])
    else $error("write one did not clear overrun flag");

  a_set_wins: assert property (st_r.phase == PXSC_RUN && split_cpl_overrun && reg_wr
    && reg_addr == `PXSC_CAP_OFS |=> st_r.flags[`PXSC_FLG_OVR])
    else $error("clear beat a simultaneous set");

  a_rsvd_zero: assert property (reg_rd && reg_addr == `PXSC_CAP_OFS |=> reg_rdata[31:25] == 7'h00)
    else $error("reserved bits read nonzero");

  a_irq_level: assert property (##1 irq == |($past(st_r.flags) & $past(st_r.mask)))
    else $error("interrupt does not follow masked flags");

  a_rdata_once: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside the answer cycle");

  // Mask register reads back in the flag layout with every other bit zero
  a_mask_read: assert property (reg_rd && reg_addr == `PXSC_MASK_OFS |=> reg_rdata[31:22] == 10'h000
    && reg_rdata[17:0] == 18'h0_0000 && reg_rdata[21:18] == $past(st_r.mask))
    else $error("mask register reads wrong");

  // Unmapped reads answer zero, so software never sees stale data
  a_unmapped_zero: assert property (reg_rd && reg_addr != `PXSC_CAP_OFS && reg_addr != `PXSC_MASK_OFS
    |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  // The straps are taken exactly once, from the synchronised pins
  a_strap_latch: assert property (st_r.phase == PXSC_SETTLE |=> st_r.phase == PXSC_RUN
    && st_r.fwd == $past(sync_fwd) && st_r.wide == $past(sync_wide))
    else $error("straps not latched on leaving settle");

  // Mode and strap stay fixed from the latch until the next reset
  a_mode_fixed: assert property (st_r.phase == PXSC_RUN
    |=> $stable(st_r.fwd) && $stable(st_r.wide))
    else $error("mode or strap changed after latch");

  // Reverse mode hides both secondary capability bits
  a_rev_caps: assert property (cap_rd && !st_r.fwd |=> reg_rdata[17:16] == 2'b00)
    else $error("capability bits set in reverse mode");

  // No flag may rise before the mode is known
  a_early_events: assert property (st_r.phase != PXSC_RUN |=> (st_r.flags & ~$past(st_r.flags)) == 4'h0)
    else $error("flag rose before the mode was latched");

  // Sticky flags survive every cycle that carries no clear for them
  a_disc_sticky: assert property (st_r.fwd && st_r.flags[`PXSC_FLG_DISC] && !(reg_wr
    && reg_addr == `PXSC_CAP_OFS && reg_wdata[`PXSC_FLG_LSB + `PXSC_FLG_DISC]) |=> st_r.flags[`PXSC_FLG_DISC])
    else $error("discard flag lost without a clear");

  a_ovr_sticky: assert property (st_r.flags[`PXSC_FLG_OVR] && !(reg_wr
    && reg_addr == `PXSC_CAP_OFS && reg_wdata[`PXSC_FLG_LSB + `PXSC_FLG_OVR]) |=> st_r.flags[`PXSC_FLG_OVR])
    else $error("overrun flag lost without a clear");

  a_dly_sticky: assert property (st_r.flags[`PXSC_FLG_DLY] && !(reg_wr
    && reg_addr == `PXSC_CAP_OFS && reg_wdata[`PXSC_FLG_LSB + `PXSC_FLG_DLY]) |=> st_r.flags[`PXSC_FLG_DLY])
    else $error("delayed-request flag lost without a clear");

  // Main scenarios the bench is expected to reach
  c_fwd_discard: cover property (st_r.fwd && split_cpl_discard ##1 st_r.flags[`PXSC_FLG_DISC]);
  c_rev_unexp: cover property (!st_r.fwd && st_r.phase == PXSC_RUN && unexp_split_cpl ##1 st_r.flags[`PXSC_FLG_UNEXP]);
  c_irq_rise: cover property (!irq ##1 irq);
  c_clear_flag: cover property (st_r.flags[`PXSC_FLG_DLY] ##1 !st_r.flags[`PXSC_FLG_DLY]);
  c_set_clear: cover property (split_cpl_overrun && reg_wr && reg_addr == `PXSC_CAP_OFS ##1 st_r.flags[`PXSC_FLG_OVR]);

endmodule : pxsc_caps

`default_nettype wire

// [pxsc_agent.sv]
/*
  Event source standing in for the secondary bus agents and the datapath.
  Assumes clk is the block clock; every event is a one-cycle pulse.
*/
`timescale 1ns/1ps
`default_nettype none

module pxsc_agent (
  input wire logic clk,
  output logic [3:0] ev
);
  // Quiet until a pulse is asked for
  initial ev = 4'h0;

  // One pulse, launched just after an edge so the design samples it cleanly
  task automatic fire(input logic [3:0] b);
    @(posedge clk);
    ev <= b;
    @(posedge clk);
    ev <= 4'h0;
  endtask : fire
endmodule : pxsc_agent

`default_nettype wire

// [pxsc_caps_bench.sv]
/*
  Self-checking bench for pxsc_caps against a behavioural register model.
  Assumes the package, the design files and pxsc_agent compile first.
*/
`timescale 1ns/1ps
`default_nettype none

module pxsc_caps_bench;
  import pxsc_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic fwd = 1'b0;
  logic wide = 1'b0;
  pxsc_freq_t freq = 3'h0;
  logic [3:0] ev;
  logic irq;
  int fails = 0;
  int checks_done = 0;
  // Model of the register state
  logic m_fwd, m_wide;
  logic [2:0] m_freq;
  logic [3:0] m_flags, m_mask;
  logic [31:0] d;
  logic [7:0] a;
  // Random wide strap, taken inverted for the last reset so both values are seen
  logic w_rand;

  pxsc_caps dut_u (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fwd_mode_pin(fwd),
    .wide_bus_strap(wide), .sec_freq_pin(freq), .split_cpl_discard(ev[0]),
    .unexp_split_cpl(ev[1]), .split_cpl_overrun(ev[2]), .split_req_delayed(ev[3]), .irq(irq));
  pxsc_agent agent_u (.clk(clk), .ev(ev));

  // 100 ns clock
  initial begin
    forever #50 clk = ~clk;
  end

  // Compare and count
  task automatic chk(input string what, input logic [31:0] want, input logic [31:0] got);
    checks_done++;
    if (got !== want) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, want, got);
    end
  endtask : chk

  // Expected capability dword; frequency hidden in reverse mode
  function automatic logic [31:0] cap_word();
    return {7'h00, m_fwd ? m_freq : 3'h0, m_flags, m_fwd, m_fwd & m_wide, 16'h9007};
  endfunction : cap_word

  // Reset with straps; pins held stable through strap capture
  task automatic rst(input logic f, input logic w);
    @(posedge clk);
    arst_n <= 1'b0;
    fwd <= f;
    wide <= w;
    freq <= 3'h0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    {m_fwd, m_wide, m_freq, m_flags, m_mask} = {f, w, 3'h0, 4'h0, 4'h0};
    repeat (3) @(posedge clk);
  endtask : rst

  // One-cycle write; model clears flags or loads the mask
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= wd;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (ad == 8'h80) m_flags &= ~wd[21:18];
    else if (ad == 8'hF0) m_mask = wd[21:18];
  endtask : wr

  // One-cycle read; data checked in the single cycle it stands
  task automatic rd(input logic [7:0] ad, input logic [31:0] want);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", want, reg_rdata);
  endtask : rd

  // Events only stick where the latched mode allows the bit
  task automatic fire(input logic [3:0] b);
    agent_u.fire(b);
    m_flags |= b & (m_fwd ? 4'hD : 4'hE);
  endtask : fire

  // Interrupt follows the masked flags after a short settle
  task automatic irq_chk();
    repeat (3) @(posedge clk);
    #1;
    chk("irq", 32'(|(m_flags & m_mask)), 32'(irq));
  endtask : irq_chk

  // Verdict and end of run
  task automatic wrap_up();
    if (fails == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    d = $urandom(94);
    rst(1'b0, 1'b1);
    rd(8'h80, cap_word());
    @(posedge clk);
    freq <= 3'h2;
    m_freq = 3'h2;
    repeat (6) @(posedge clk);
    rd(8'h80, cap_word());
    fire(4'hF);
    rd(8'h80, cap_word());
    wr(8'h80, 32'hFFFF_FFFF);
    rd(8'h80, cap_word());
    // Forward mode with a random wide strap
    w_rand = 1'($urandom);
    rst(1'b1, w_rand);
    rd(8'h80, cap_word());
    for (int i = 0; i < 4; i++) begin
      fire(4'(1 << i));
      rd(8'h80, cap_word());
    end
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      freq <= 3'(i);
      m_freq = 3'(i);
      repeat (5) @(posedge clk);
      rd(8'h80, cap_word());
    end
    // Mask, interrupt raise and clear
    d = $urandom() | 32'h0010_0000;
    wr(8'hF0, d);
    rd(8'hF0, 32'(m_mask) << 18);
    irq_chk();
    wr(8'h80, 32'h003C_0000);
    irq_chk();
    // Set and clear in the same cycle: set must win
    fork
      wr(8'h80, 32'h0010_0000);
      agent_u.fire(4'h4);
    join
    m_flags[2] = 1'b1;
    rd(8'h80, cap_word());
    irq_chk();
    // Unmapped place: write ignored, read zero
    a = 8'($urandom);
    if (a == 8'h80 || a == 8'hF0) a = 8'h81;
    wr(a, $urandom);
    rd(a, 32'h0000_0000);
    rd(8'h80, cap_word());
    // Third reset mid-run returns to reverse values
    rst(1'b0, 1'b1);
    rd(8'h80, cap_word());
    // Back to forward with the other wide strap value
    rst(1'b1, !w_rand);
    rd(8'h80, cap_word());
    wrap_up();
  end

  // Hang guard well beyond the roughly 200 cycles the tests need
  initial begin
    #(20000 * 100);
    fails++;
    wrap_up();
  end
endmodule : pxsc_caps_bench

`default_nettype wire
